// ===== pkg/spd_pkg.sv
package spd_pkg;

    // ==========================================================
    // Core clock and timing
    // ==========================================================
    localparam int CORE_CLK_PERIOD_NS = 50;
    // Bounds on the final-edge-to-output-change window, in core clock periods.
    localparam int SLH_MIN_CYC = 6;
    localparam int SLH_MAX_CYC = 8;
    // Pin to edge-detect latency through the two-flop synchroniser and edge register.
    localparam int SYNC_LAT_CYC = 3;
    localparam logic [2:0] SLH_HOLD_CYC = 3'((SLH_MIN_CYC + SLH_MAX_CYC) / 2 - SYNC_LAT_CYC);
    localparam logic [2:0] LAST_BIT_IDX = 3'h7;
    localparam logic [3:0] LAST_HALF_IDX = 4'hf;

    // ==========================================================
    // Register map
    // ==========================================================
    localparam int ADDR_W = 12;
    localparam logic [7:0] IDX_CTRL = 8'ha1;
    localparam logic [7:0] IDX_RATE = 8'ha2;
    localparam logic [7:0] IDX_DATA = 8'ha3;
    localparam logic [7:0] IDX_STAT = 8'ha4;
    localparam logic [7:0] IDX_IEN = 8'ha5;
    localparam logic [7:0] IDX_ICLR = 8'ha6;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = {2'b00, IDX_CTRL, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_RATE = {2'b00, IDX_RATE, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_DATA = {2'b00, IDX_DATA, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_STAT = {2'b00, IDX_STAT, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_IEN = {2'b00, IDX_IEN, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_ICLR = {2'b00, IDX_ICLR, 2'b00};

    // ==========================================================
    // Field positions and reset values
    // ==========================================================
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_MST_BIT = 1;
    localparam int CTRL_CPOL_BIT = 2;
    localparam int CTRL_CPHA_BIT = 3;
    localparam int STAT_TXE_BIT = 0;
    localparam int STAT_RXF_BIT = 1;
    localparam int STAT_BUSY_BIT = 2;
    localparam int STAT_EV_LSB = 4;
    localparam int EV_W = 3;
    localparam int EV_DONE_BIT = 0;
    localparam int EV_WRITE_COLLISION_FLAG_BIT = 1;
    localparam int EV_OVR_BIT = 2;
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam logic [7:0] RATE_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [EV_W-1:0] EV_RST = 3'h0;

    // ==========================================================
    // Engine states
    // ==========================================================
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_HOLD = 2'b11
    } spd_state_t;

endpackage : spd_pkg

// ===== src/spd_sync2.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Two-flop synchroniser
// ==========================================================
module spd_sync2 #(
    parameter logic RST_VAL = 1'b0
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Data
    input wire logic d,
    output logic q
);

    logic meta_r;
    logic q_r;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta_r <= RST_VAL;
            q_r <= RST_VAL;
        end else begin
            meta_r <= d;
            q_r <= meta_r;
        end
    end

    assign q = q_r;

endmodule : spd_sync2

`default_nettype wire

// ===== src/spd_spi_port.sv
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Data write fills transmit buffer, not lines.
// - Master write starts transfer; slave waits.
// - Data read returns receive buffer.
// - Polarity one inverts idle level and edges.
// - Slave MISO valid within four after select falls.
// - Slave MISO released within four after select rises.
// - Slave MISO updates within four after shift.
// - Phase one: MISO changes 6-8 after last.
// - Empty flag clears on write, sets on move.
// - Write while full ignored, sets collision flag.
// - Slave receive with unread buffer sets overrun.
module spd_spi_port
    import spd_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt
    output logic irq,
    // Serial clock
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    // Master out, slave in
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe,
    // Master in, slave out
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe,
    // Slave select
    input wire logic slave_select_n,
    output logic ss_out_n,
    output logic ss_oe
);

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    logic sck_s;
    logic mosi_s;
    logic miso_s;
    logic ss_n_s;

    spd_sync2 #(.RST_VAL(1'b0)) u_sync_sck (.clk_sys(clk_sys), .rst(rst), .d(sck_in), .q(sck_s));
    spd_sync2 #(.RST_VAL(1'b0)) u_sync_mosi (.clk_sys(clk_sys), .rst(rst), .d(mosi_in), .q(mosi_s));
    spd_sync2 #(.RST_VAL(1'b0)) u_sync_miso (.clk_sys(clk_sys), .rst(rst), .d(miso_in), .q(miso_s));
    spd_sync2 #(.RST_VAL(1'b1)) u_sync_ss (.clk_sys(clk_sys), .rst(rst),
        .d(slave_select_n), .q(ss_n_s));

    // ==========================================================
    // State
    // ==========================================================
    logic [3:0] ctrl_r, ctrl_nxt;
    logic [7:0] rate_r, rate_nxt;
    logic [7:0] txbuf_r, txbuf_nxt;
    logic [7:0] rxbuf_r, rxbuf_nxt;
    logic [7:0] sr_r, sr_nxt;
    logic tx_empty_r, tx_empty_nxt;
    logic rx_full_r, rx_full_nxt;
    logic [EV_W-1:0] ev_r, ev_nxt;
    logic [EV_W-1:0] ien_r, ien_nxt;
    spd_state_t state_r, state_nxt;
    logic [2:0] bitcnt_r, bitcnt_nxt;
    logic [3:0] half_r, half_nxt;
    logic [7:0] div_r, div_nxt;
    logic sckn_r, sckn_nxt;
    logic [2:0] hold_r, hold_nxt;
    logic dout_r, dout_nxt;
    logic sck_prev_r, sck_prev_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;
    logic irq_r, irq_nxt;
    logic sck_out_r, sck_out_nxt;
    logic sck_oe_r, sck_oe_nxt;
    logic mosi_oe_r, mosi_oe_nxt;
    logic miso_oe_r, miso_oe_nxt;
    logic ss_out_n_r, ss_out_n_nxt;
    logic ss_oe_r, ss_oe_nxt;

    // ==========================================================
    // Next-state logic
    // ==========================================================
    always_comb begin
        logic setup;
        logic wr;
        logic rd;
        logic mapped;
        logic en;
        logic mst;
        logic cpol;
        logic cpha;
        logic ss_low;
        logic lead;
        logic trail;
        logic sample;
        logic shift;
        logic din;
        logic done;
        logic load;
        logic [7:0] sr_load;
        logic [EV_W-1:0] ev_set;
        logic [EV_W-1:0] ev_clr;
        setup = psel & ~penable;
        wr = psel & penable & pready_r & pwrite;
        rd = psel & penable & pready_r & ~pwrite;
        mapped = (paddr == ADDR_CTRL) | (paddr == ADDR_RATE) | (paddr == ADDR_DATA)
            | (paddr == ADDR_STAT) | (paddr == ADDR_IEN) | (paddr == ADDR_ICLR);
        en = ctrl_r[CTRL_EN_BIT];
        mst = ctrl_r[CTRL_MST_BIT];
        cpol = ctrl_r[CTRL_CPOL_BIT];
        cpha = ctrl_r[CTRL_CPHA_BIT];
        ss_low = ~ss_n_s;
        din = mst ? miso_s : mosi_s;
        lead = 1'b0;
        trail = 1'b0;
        done = 1'b0;
        load = 1'b0;
        ev_set = '0;
        ev_clr = '0;
        sr_load = tx_empty_r ? sr_r : txbuf_r;

        ctrl_nxt = ctrl_r;
        rate_nxt = rate_r;
        txbuf_nxt = txbuf_r;
        rxbuf_nxt = rxbuf_r;
        sr_nxt = sr_r;
        tx_empty_nxt = tx_empty_r;
        rx_full_nxt = rx_full_r;
        ien_nxt = ien_r;
        state_nxt = state_r;
        bitcnt_nxt = bitcnt_r;
        half_nxt = half_r;
        div_nxt = div_r;
        sckn_nxt = sckn_r;
        hold_nxt = hold_r;
        dout_nxt = dout_r;
        // Edges are found on the normalised clock, so one detector serves both polarities.
        sck_prev_nxt = sck_s;
        if (((sck_s ^ cpol) & ~(sck_prev_r ^ cpol)) & ~mst & ss_low) begin
            lead = 1'b1;
        end
        if ((~(sck_s ^ cpol) & (sck_prev_r ^ cpol)) & ~mst & ss_low) begin
            trail = 1'b1;
        end

        // Bus registers.
        pready_nxt = setup;
        prdata_nxt = prdata_r;
        pslverr_nxt = pslverr_r;
        if (setup) begin
            pslverr_nxt = ~mapped;
            prdata_nxt = 32'h0000_0000;
            unique case (paddr)
                ADDR_CTRL: prdata_nxt[3:0] = ctrl_r;
                ADDR_RATE: prdata_nxt[7:0] = rate_r;
                ADDR_DATA: prdata_nxt[7:0] = rxbuf_r;
                ADDR_STAT: begin
                    prdata_nxt[STAT_TXE_BIT] = tx_empty_r;
                    prdata_nxt[STAT_RXF_BIT] = rx_full_r;
                    prdata_nxt[STAT_BUSY_BIT] = (state_r != ST_IDLE);
                    prdata_nxt[STAT_EV_LSB +: EV_W] = ev_r;
                end
                ADDR_IEN: prdata_nxt[EV_W-1:0] = ien_r;
                default: prdata_nxt = 32'h0000_0000;
            endcase
        end
        if (wr && paddr == ADDR_CTRL) begin
            ctrl_nxt = pwdata[3:0];
        end
        if (wr && paddr == ADDR_RATE) begin
            rate_nxt = pwdata[7:0];
        end
        if (wr && paddr == ADDR_IEN) begin
            ien_nxt = pwdata[EV_W-1:0];
        end
        if (wr && paddr == ADDR_ICLR) begin
            ev_clr = pwdata[EV_W-1:0];
        end
        if (wr && paddr == ADDR_DATA) begin
            if (tx_empty_r) begin
                txbuf_nxt = pwdata[7:0];
                tx_empty_nxt = 1'b0;
            end else begin
                ev_set[EV_WRITE_COLLISION_FLAG_BIT] = 1'b1;
            end
        end
        if (rd && paddr == ADDR_DATA) begin
            rx_full_nxt = 1'b0;
        end

        // Master clock divider: each half period is rate_r + 1 core clocks.
        if (mst && state_r == ST_RUN) begin
            if (div_r == rate_r) begin
                div_nxt = 8'h00;
                sckn_nxt = ~sckn_r;
                half_nxt = 4'(half_r + 4'h1);
                lead = ~sckn_r;
                trail = sckn_r;
            end else begin
                div_nxt = 8'(div_r + 8'h01);
            end
        end
        sample = cpha ? trail : lead;
        shift = cpha ? lead : trail;

        unique case (state_r)
            ST_IDLE: begin
                if (en && mst && !tx_empty_r) begin
                    load = 1'b1;
                end else if (en && !mst && ss_low) begin
                    load = 1'b1;
                end
            end
            ST_RUN: begin
                if (shift) begin
                    dout_nxt = sr_r[7];
                end
                if (sample) begin
                    // Master sampling goes through the synchroniser, so MISO setup must cover it.
                    sr_nxt = {sr_r[6:0], din};
                    bitcnt_nxt = 3'(bitcnt_r + 3'h1);
                    done = (bitcnt_r == LAST_BIT_IDX);
                end
                if (mst && lead && half_r == LAST_HALF_IDX) begin
                    state_nxt = ST_IDLE;
                end else if (mst && trail && half_r == LAST_HALF_IDX) begin
                    state_nxt = ST_IDLE;
                end else if (!mst && done) begin
                    if (cpha) begin
                        state_nxt = ST_HOLD;
                        hold_nxt = 3'h0;
                    end else begin
                        state_nxt = ST_IDLE;
                    end
                end
            end
            ST_HOLD: begin
                hold_nxt = 3'(hold_r + 3'h1);
                if (hold_r == 3'(SLH_HOLD_CYC - 3'h1)) begin
                    load = 1'b1;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase

        if (done) begin
            rxbuf_nxt = sr_nxt;
            rx_full_nxt = 1'b1;
            ev_set[EV_DONE_BIT] = 1'b1;
            if (rx_full_r && !mst) begin
                ev_set[EV_OVR_BIT] = 1'b1;
            end
        end

        if (load) begin
            state_nxt = ST_RUN;
            sr_nxt = sr_load;
            dout_nxt = sr_load[7];
            bitcnt_nxt = 3'h0;
            half_nxt = 4'h0;
            div_nxt = 8'h00;
            sckn_nxt = 1'b0;
            if (!tx_empty_r) begin
                tx_empty_nxt = 1'b1;
            end
        end

        // Loss of enable or of the select aborts the byte and leaves the buffers alone.
        if (!en || (!mst && !ss_low)) begin
            state_nxt = ST_IDLE;
            bitcnt_nxt = 3'h0;
            sckn_nxt = 1'b0;
        end

        // A new event beats a clear written in the same cycle.
        ev_nxt = (ev_r & ~ev_clr) | ev_set;
        irq_nxt = |(ev_nxt & ien_nxt);

        // Pin drivers.
        sck_out_nxt = (mst && state_nxt == ST_RUN) ? (sckn_nxt ^ cpol) : cpol;
        sck_oe_nxt = en & mst;
        mosi_oe_nxt = en & mst;
        ss_oe_nxt = en & mst;
        ss_out_n_nxt = ~(mst && state_nxt == ST_RUN);
        miso_oe_nxt = en & ~mst & ss_low;
    end

    // ==========================================================
    // Registers
    // ==========================================================
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl_r <= CTRL_RST;
            rate_r <= RATE_RST;
            txbuf_r <= DATA_RST;
            rxbuf_r <= DATA_RST;
            sr_r <= DATA_RST;
            tx_empty_r <= 1'b1;
            rx_full_r <= 1'b0;
            ev_r <= EV_RST;
            ien_r <= EV_RST;
            state_r <= ST_IDLE;
            bitcnt_r <= 3'h0;
            half_r <= 4'h0;
            div_r <= 8'h00;
            sckn_r <= 1'b0;
            hold_r <= 3'h0;
            dout_r <= 1'b0;
            sck_prev_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            irq_r <= 1'b0;
            sck_out_r <= 1'b0;
            sck_oe_r <= 1'b0;
            mosi_oe_r <= 1'b0;
            miso_oe_r <= 1'b0;
            ss_out_n_r <= 1'b1;
            ss_oe_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            rate_r <= rate_nxt;
            txbuf_r <= txbuf_nxt;
            rxbuf_r <= rxbuf_nxt;
            sr_r <= sr_nxt;
            tx_empty_r <= tx_empty_nxt;
            rx_full_r <= rx_full_nxt;
            ev_r <= ev_nxt;
            ien_r <= ien_nxt;
            state_r <= state_nxt;
            bitcnt_r <= bitcnt_nxt;
            half_r <= half_nxt;
            div_r <= div_nxt;
            sckn_r <= sckn_nxt;
            hold_r <= hold_nxt;
            dout_r <= dout_nxt;
            sck_prev_r <= sck_prev_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            irq_r <= irq_nxt;
            sck_out_r <= sck_out_nxt;
            sck_oe_r <= sck_oe_nxt;
            mosi_oe_r <= mosi_oe_nxt;
            miso_oe_r <= miso_oe_nxt;
            ss_out_n_r <= ss_out_n_nxt;
            ss_oe_r <= ss_oe_nxt;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign irq = irq_r;
    assign sck_out = sck_out_r;
    assign sck_oe = sck_oe_r;
    assign mosi_out = dout_r;
    assign mosi_oe = mosi_oe_r;
    assign miso_out = dout_r;
    assign miso_oe = miso_oe_r;
    assign ss_out_n = ss_out_n_r;
    assign ss_oe = ss_oe_r;

endmodule : spd_spi_port

`default_nettype wire

// ===== tb/spd_spi_port_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port checker
module spd_spi_port_asserts
    import spd_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq,
    // Serial pins
    input wire logic sck_in,
    input wire logic sck_out,
    input wire logic sck_oe,
    input wire logic mosi_in,
    input wire logic mosi_out,
    input wire logic mosi_oe,
    input wire logic miso_in,
    input wire logic miso_out,
    input wire logic miso_oe,
    input wire logic slave_select_n,
    input wire logic ss_out_n,
    input wire logic ss_oe
);
    logic sck_q;
    logic [3:0] edge_age;
    logic [3:0] ss_age;
    // Ages count core clocks since the raw clock pin changed or the select pin fell, saturating at 15.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sck_q <= 1'b0;
            edge_age <= 4'hf;
            ss_age <= 4'h0;
        end else begin
            sck_q <= sck_in;
            edge_age <= (sck_in != sck_q) ? 4'h1 : edge_age + 4'(edge_age != 4'hf);
            ss_age <= slave_select_n ? 4'h0 : ss_age + 4'(ss_age != 4'hf);
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    AST_READY_PULSE: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("pready not a single answer cycle");
    AST_READY_IDLE: assert property (!psel |=> !pready)
        else $error("pready without select");
    AST_ERR_ZERO: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    AST_MSTR_START: assert property (psel && penable && pready && pwrite && !pslverr
        && paddr == ADDR_DATA && sck_oe && ss_out_n |-> ##[1:3] !ss_out_n)
        else $error("master write did not start");
    AST_SLV_QUIET: assert property (!sck_oe ##1 !sck_oe |-> ss_out_n)
        else $error("select driven outside master");
    AST_MISO_VALID: assert property ($rose(miso_oe) |-> ss_age inside {[1:4]})
        else $error("miso enabled late");
    AST_MISO_RELEASE: assert property ($rose(slave_select_n) |-> ##[0:4] !miso_oe)
        else $error("miso not released");
    AST_MISO_SHIFT: assert property ($changed(miso_out) && miso_oe && $past(miso_oe)
        && !slave_select_n && ss_age > 4'h5 |-> edge_age <= 4'h4 || edge_age inside {[6:8]})
        else $error("miso changed off schedule");
    cover property ($fell(ss_out_n));
    cover property ($rose(miso_oe));
    cover property (pready && pslverr);
    cover property ($rose(irq));
endmodule : spd_spi_port_asserts
`default_nettype wire

// ===== tb/spd_spi_peer.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Far-side device: slave to our master, master to our slave
module spd_spi_peer #(
    parameter int HALF = 5
) (
    // Control from bench
    input wire logic clk_sys,
    input wire logic cpol,
    input wire logic cpha,
    input wire logic [7:0] slv_byte,
    // From the block
    input wire logic sck_out,
    input wire logic mosi_out,
    input wire logic ss_out_n,
    input wire logic miso_out,
    input wire logic miso_oe,
    // To the block
    output var logic sck_in,
    output var logic mosi_in,
    output var logic slave_select_n,
    output var logic miso_in
);
    logic sq, sel_q, edge_e, shift_e;
    logic [2:0] n, r;
    logic [7:0] rcv;
    logic [7:0] got[$];
    assign edge_e = sck_out != sq;
    assign shift_e = edge_e && ((sck_out == cpol) != cpha);
    initial begin
        {sck_in, mosi_in, miso_in, sq, sel_q} = 5'h0;
        slave_select_n = 1'b1;
    end
    always @(posedge clk_sys) begin
        sq <= sck_out;
        sel_q <= ss_out_n;
        // Edges are seen one clock late, so the select is judged with the same delay.
        if (edge_e && !shift_e && !sel_q) begin
            rcv <= {rcv[6:0], mosi_out};
            r <= r + 3'h1;
            if (r == 3'h7) got.push_back({rcv[6:0], mosi_out});
        end else if (ss_out_n) begin
            r <= 3'h0;
        end
        if (ss_out_n) begin
            n <= 3'h0;
            miso_in <= ~miso_in;
        end else if (shift_e || (sel_q && !cpha)) begin
            // Next bit lands one clock after the shift edge, so it leads the sample edge.
            miso_in <= slv_byte[3'h7 - n];
            n <= n + 3'h1;
        end
    end
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        sck_in <= cpol;
        mosi_in <= tx[7];
        @(posedge clk_sys);
        slave_select_n <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            repeat (HALF) @(posedge clk_sys);
            sck_in <= ~sck_in;
            if (cpha) mosi_in <= tx[7 - i];
            else rx[7 - i] = miso_oe ? miso_out : 1'bx;
            repeat (HALF) @(posedge clk_sys);
            sck_in <= ~sck_in;
            if (cpha) rx[7 - i] = miso_oe ? miso_out : 1'bx;
            else if (i < 7) mosi_in <= tx[6 - i];
        end
        repeat (2 * HALF) @(posedge clk_sys);
        slave_select_n <= 1'b1;
        mosi_in <= ~mosi_in;
    endtask : xfer
endmodule : spd_spi_peer
`default_nettype wire

// ===== tb/spd_spi_port_test.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Bench
module spd_spi_port_test
    import spd_pkg::*;
;
    logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, irq, cpol, cpha;
    logic sck_in, sck_out, sck_oe, mosi_in, mosi_out, mosi_oe;
    logic miso_in, miso_out, miso_oe, slave_select_n, ss_out_n, ss_oe;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0] slv_byte, rs, tb_rx, a, b;
    logic [64:0] cur;
    logic [64:0] exp_q[$];
    int err_total, samples_checked;
    spd_spi_port uut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe),
        .mosi_in(mosi_in), .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_in),
        .miso_out(miso_out), .miso_oe(miso_oe), .slave_select_n(slave_select_n),
        .ss_out_n(ss_out_n), .ss_oe(ss_oe));
    spd_spi_peer peer (.clk_sys(clk_sys), .cpol(cpol), .cpha(cpha), .slv_byte(slv_byte),
        .sck_out(sck_out), .mosi_out(mosi_out), .ss_out_n(ss_out_n), .miso_out(miso_out),
        .miso_oe(miso_oe), .sck_in(sck_in), .mosi_in(mosi_in),
        .slave_select_n(slave_select_n), .miso_in(miso_in));
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            err_total++;
            $display("FAIL %0t got %h want %h", $time, seen, want);
        end
    endtask : chk
    task automatic wrap_up();
        if (err_total == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrap_up
    task automatic apb(input logic w, input logic [ADDR_W-1:0] ad, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [ADDR_W-1:0] ad, input logic [31:0] m, input logic [31:0] e,
        input logic er);
        exp_q.push_back({er, m, e});
        apb(1'b0, ad, 32'h0);
    endtask : rd
    always @(posedge clk_sys) begin
        if (psel && penable && pready && !pwrite) begin
            cur = (exp_q.size() > 0) ? exp_q.pop_front() : 65'h0;
            chk(prdata & cur[63:32], cur[31:0]);
            chk({31'h0, pslverr}, {31'h0, cur[64]});
        end
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        wrap_up();
    end
    initial begin
        {rst, psel, penable, pwrite, cpol, cpha} = 6'h20;
        paddr = 12'h000;
        pwdata = 32'h0;
        slv_byte = 8'h00;
        rs = 8'h2e;
        err_total = 0;
        samples_checked = 0;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        apb(1'b1, ADDR_STAT, 32'h0);
        rd(ADDR_CTRL, 32'hffffffff, 32'h0, 1'b0);
        rd(ADDR_RATE, 32'hffffffff, 32'h0, 1'b0);
        rd(ADDR_DATA, 32'hffffffff, 32'h0, 1'b0);
        rd(ADDR_STAT, 32'hffffffff, 32'h1, 1'b0);
        rd(ADDR_IEN, 32'hffffffff, 32'h0, 1'b0);
        rd(12'h004, 32'hffffffff, 32'h0, 1'b1);
        apb(1'b1, ADDR_RATE, 32'h4);
        for (int md = 0; md < 4; md++) begin
            cpol <= md[0];
            cpha <= md[1];
            a = lfsr(rs);
            b = lfsr(a);
            rs = b;
            slv_byte <= a ^ b;
            apb(1'b1, ADDR_CTRL, {28'h0, 2'(md), 2'b11});
            repeat (2) @(posedge clk_sys);
            chk({31'h0, sck_out}, {31'h0, cpol});
            chk({29'h0, sck_oe, mosi_oe, ss_oe}, 32'h7);
            apb(1'b1, ADDR_DATA, {24'h0, a});
            apb(1'b1, ADDR_DATA, {24'h0, b});
            apb(1'b1, ADDR_DATA, 32'h0);
            rd(ADDR_STAT, 32'h25, 32'h24, 1'b0);
            for (int k = 0; k < 3000 && (peer.got.size() < 2 || !ss_out_n); k++) @(posedge clk_sys);
            chk(32'(peer.got.size()), 32'h2);
            chk({24'h0, peer.got.pop_front()}, {24'h0, a});
            chk({24'h0, peer.got.pop_front()}, {24'h0, b});
            rd(ADDR_DATA, 32'hff, {24'h0, a ^ b}, 1'b0);
            rd(ADDR_STAT, 32'h57, 32'h11, 1'b0);
            apb(1'b1, ADDR_ICLR, 32'h7);
        end
        for (int md = 0; md < 4; md++) begin
            cpol <= md[0];
            cpha <= md[1];
            a = lfsr(rs);
            b = lfsr(a);
            rs = b;
            apb(1'b1, ADDR_CTRL, {28'h0, 2'(md), 2'b01});
            apb(1'b1, ADDR_DATA, {24'h0, a});
            rd(ADDR_STAT, 32'h1, 32'h0, 1'b0);
            chk({29'h0, sck_oe, mosi_oe, ss_oe}, 32'h0);
            peer.xfer(b, tb_rx);
            chk({24'h0, tb_rx}, {24'h0, a});
            repeat (8) @(posedge clk_sys);
            rd(ADDR_STAT, 32'h3, 32'h3, 1'b0);
            rd(ADDR_DATA, 32'hff, {24'h0, b}, 1'b0);
        end
        apb(1'b1, ADDR_IEN, 32'h4);
        peer.xfer(a, tb_rx);
        repeat (8) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h0);
        peer.xfer(b, tb_rx);
        repeat (8) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h1);
        rd(ADDR_STAT, 32'h40, 32'h40, 1'b0);
        apb(1'b1, ADDR_IEN, 32'h0);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, ADDR_IEN, 32'h4);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, ADDR_ICLR, 32'h4);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h0);
        rd(ADDR_STAT, 32'h40, 32'h0, 1'b0);
        repeat (4) @(posedge clk_sys);
        chk(32'(exp_q.size()), 32'h0);
        wrap_up();
    end
endmodule : spd_spi_port_test
bind spd_spi_port spd_spi_port_asserts chk_i (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .sck_in(sck_in), .sck_out(sck_out),
    .sck_oe(sck_oe), .mosi_in(mosi_in), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
    .miso_in(miso_in), .miso_out(miso_out), .miso_oe(miso_oe),
    .slave_select_n(slave_select_n), .ss_out_n(ss_out_n), .ss_oe(ss_oe));
`default_nettype wire
